// ==== hdl/usrxf_top.sv ====
`timescale 1ns/1ps
`include "usrxf_consts.svh"
module usrxf_top
   import usrxf_pkg::*;
#(
   parameter int DATA_W = `USRXF_DATA_W
) (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        sync_fmt_i,
   input  wire usrxf_word_s word_i,
   input  wire usrxf_line_s line_i,
   input  wire logic [7:0]  sync_char_i,
   input  wire logic        sync_fs_wr_i,
   input  wire logic        sync_fs_val_i,
   input  wire logic        stat_rd_i,
   output logic             brk_fs_flag_o,
   output logic             char_assembling_flag_o,
   output logic             brk_irq_o,
   output logic             brk_end_irq_o
);
   ////////////////////////////////////////////////////////////
   // Break detection
   logic in_break_r;
   logic rd_seen_r;
   logic brk_r;

   logic sync_fmt_q;
   // Mode bit is a host setting that may change at any time; costs two cycles of lag
   usrxf_sync u_fmt_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .d_i       (sync_fmt_i),
      .q_o       (sync_fmt_q)
   );
   wire async_fmt  = ~sync_fmt_q;
   wire brk_word   = async_fmt & word_i.xfer & (word_i.data == '0) & ~word_i.stop_ok;
   wire one_bit    = line_i.data_bit_stb & (line_i.data_bit == `USRXF_ONE);
   wire brk_ends   = in_break_r & one_bit;
   wire rd_done    = rd_seen_r | stat_rd_i;
   // Clear needs both the end and a read; a fresh break word wins
   wire brk_clr    = brk_r & ~brk_word & rd_done & (brk_ends | ~in_break_r);
   wire sync_match = word_i.xfer & (word_i.data == sync_char_i);

   logic brk_nxt;
   always_comb begin
      brk_nxt = brk_r;
      if (sync_fmt_q) begin
         if (sync_fs_wr_i)
            brk_nxt = sync_fs_val_i;
         if (sync_match)
            brk_nxt = `USRXF_ONE;
      end else if (brk_word) begin
         brk_nxt = `USRXF_ONE;
      end else if (brk_clr) begin
         brk_nxt = `USRXF_ZERO;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         in_break_r    <= `USRXF_ZERO;
         rd_seen_r     <= `USRXF_ZERO;
         brk_r         <= `USRXF_ZERO;
         brk_irq_o     <= `USRXF_ZERO;
         brk_end_irq_o <= `USRXF_ZERO;
      end else begin
         in_break_r    <= brk_word | (in_break_r & ~one_bit);
         rd_seen_r     <= brk_word ? `USRXF_ZERO : (brk_r & rd_done);
         brk_r         <= brk_nxt;
         brk_irq_o     <= brk_word;
         brk_end_irq_o <= async_fmt & brk_clr;
      end
   end
   assign brk_fs_flag_o = brk_r;

   ////////////////////////////////////////////////////////////
   // Shared match / in-progress bit
   logic assembling_r;
   logic assembling_nxt;
   always_comb begin
      assembling_nxt = assembling_r;
      if (sync_fmt_q) begin
         if (word_i.xfer)
            assembling_nxt = sync_match;
      end else if (line_i.start_det) begin
         assembling_nxt = `USRXF_ONE;
      end else if (line_i.word_end) begin
         assembling_nxt = `USRXF_ZERO;
      end
   end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i)
         assembling_r <= `USRXF_ZERO;
      else
         assembling_r <= assembling_nxt;
   end
   assign char_assembling_flag_o = assembling_r;
endmodule : usrxf_top

// ==== hdl/usrxf_consts.svh ====
// Summary of operation
// - Async all-zero word, missing stop: break
// - Break lasts until a one data bit
// - Break flag sets on break word transfer
// - Break detection raises interrupt request
// - Clear after break end and status read
// - Async: break flag clearing raises end-of-break interrupt
// - Sync: matching transferred word sets shared bit
// - Sync: mismatching transferred word clears shared bit
// - Async: start bit sets character-in-progress
// - Async: final stop bit clears it
// - Break bit doubles as sync found/search
`ifndef USRXF_CONSTS_SVH
`define USRXF_CONSTS_SVH
`define USRXF_DATA_W  8
`define USRXF_ZERO    1'b0
`define USRXF_ONE     1'b1
`endif

// ==== hdl/usrxf_pkg.sv ====
package usrxf_pkg;
   typedef struct packed {
      logic       xfer;       // Word moved into receive buffer
      logic [7:0] data;       // Word value
      logic       stop_ok;    // Stop bit seen as one
   } usrxf_word_s;
   typedef struct packed {
      logic start_det;        // Start bit detected
      logic data_bit_stb;     // A data bit was sampled
      logic data_bit;         // Its value
      logic word_end;         // Final stop bit received
   } usrxf_line_s;
endpackage : usrxf_pkg

// ==== hdl/usrxf_sync.sv ====
`timescale 1ns/1ps
module usrxf_sync (
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic meta_r;
   // Two stages; only the second stage is read
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta_r <= 1'b0;
         q_o    <= 1'b0;
      end else begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule : usrxf_sync

// ==== bench/usrxf_monitor.sv ====
`timescale 1ns/1ps
module usrxf_monitor
   import usrxf_pkg::*;
(
   input wire logic        clk_i, sys_rst_i, sync_fmt_i, stat_rd_i, brk_fs_flag_o,
   input wire logic        char_assembling_flag_o, brk_irq_o, brk_end_irq_o,
   input wire logic [7:0]  sync_char_i,
   input wire usrxf_word_s word_i,
   input wire usrxf_line_s line_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   wire one_w  = line_i.data_bit_stb && line_i.data_bit;
   wire hit_w  = sync_fmt_i && word_i.xfer && word_i.data == sync_char_i;
   wire keep_w = brk_fs_flag_o && !sync_fmt_i && !stat_rd_i && !one_w;
   sequence s_brk; !sync_fmt_i && word_i.xfer && word_i.data == 8'h00 && !word_i.stop_ok; endsequence
   sequence s_ack; !sync_fmt_i && brk_fs_flag_o && stat_rd_i ##[1:20] one_w; endsequence
   a_brk_set: assert property (s_brk |=> brk_fs_flag_o && brk_irq_o) else $error("set");
   a_brk_hold: assert property (keep_w |=> brk_fs_flag_o) else $error("hold");
   a_brk_ack: assert property (s_ack |=> !brk_fs_flag_o) else $error("ack");
   a_end_irq: assert property ($fell(brk_fs_flag_o) && !sync_fmt_i |-> brk_end_irq_o)
      else $error("eirq");
   a_sync_hit: assert property (hit_w |=> char_assembling_flag_o && brk_fs_flag_o)
      else $error("hit");
   a_sync_miss: assert property (sync_fmt_i && word_i.xfer && !hit_w |=> !char_assembling_flag_o)
      else $error("miss");
   a_cip_set: assert property (!sync_fmt_i && line_i.start_det |=> char_assembling_flag_o)
      else $error("cip");
   a_cip_end: assert property (!sync_fmt_i && line_i.word_end && !line_i.start_det |=> !char_assembling_flag_o)
      else $error("end");
endmodule : usrxf_monitor
bind usrxf_top usrxf_monitor u_mon (.*);

// ==== bench/usrxf_line_model.sv ====
`timescale 1ns/1ps
module usrxf_line_model
   import usrxf_pkg::*;
(
   input  wire logic  clk_i,
   output usrxf_word_s word_o = '0,
   output usrxf_line_s line_o = '0
);
   task automatic put(input usrxf_word_s w, input usrxf_line_s l);
      @(posedge clk_i);
      word_o <= w;
      line_o <= l;
      @(posedge clk_i);
      word_o <= ~w & 10'h1FF; // Released word has xfer cleared, so stale inverted data never counts as a match
      line_o <= '0;
   endtask : put
endmodule : usrxf_line_model

// ==== bench/tb_usart_rx_status_flags.sv ====
`timescale 1ns/1ps
`define CHK(n, e, v) begin compares++; if ((v) !== (e)) begin failures++; $display("CHECK FAILED %s exp %h got %h", n, e, v); end end
module tb_usart_rx_status_flags;
   import usrxf_pkg::*;
   logic        clk_i = 1'h0, sys_rst_i = 1'h1, sync_fmt_i = 1'h0, stat_rd_i = 1'h0;
   logic        sync_fs_wr_i = 1'h0, brk_fs_flag_o, char_assembling_flag_o, brk_irq_o, brk_end_irq_o;
   logic [7:0]  sync_char_i = 8'hA5;
   logic        sync_fs_val_i = 1'h0;
   usrxf_word_s word_i;
   usrxf_line_s line_i;
   int          failures = 0, compares = 0;
   initial forever #25 clk_i = ~clk_i;
   usrxf_line_model u_tx (.clk_i, .word_o(word_i), .line_o(line_i));
   usrxf_top u_dut (.*);
   // Control bits ride along the whole transfer, flags are compared as one vector
   task automatic step(input usrxf_word_s w, input usrxf_line_s l, input logic [2:0] c,
                       input logic [3:0] e);
      {sync_fs_val_i, sync_fs_wr_i, stat_rd_i} <= c;
      u_tx.put(w, l);
      {sync_fs_val_i, sync_fs_wr_i, stat_rd_i} <= 3'h0;
      #1;
      `CHK("flags", e, {brk_fs_flag_o, char_assembling_flag_o, brk_irq_o, brk_end_irq_o})
   endtask : step
   task automatic end_of_test;
      if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (8) @(posedge clk_i);
      sys_rst_i <= 1'h0;
      step(10'h200, 4'h0, 3'h0, 4'hA);
      step(10'h000, 4'h4, 3'h1, 4'h8);
      step(10'h000, 4'h6, 3'h0, 4'h1);
      step(10'h200, 4'h0, 3'h0, 4'hA);
      step(10'h000, 4'h6, 3'h0, 4'h8);
      step(10'h000, 4'h0, 3'h1, 4'h0);
      step(10'h000, 4'h8, 3'h0, 4'h4);
      step(10'h000, 4'h1, 3'h0, 4'h0);
      sync_fmt_i <= 1'h1;
      // Mode bit passes two stages before the flags see it
      repeat (2) @(posedge clk_i);
      step(10'h34B, 4'h0, 3'h0, 4'hC);
      step(10'h000, 4'h0, 3'h2, 4'h4);
      step(10'h000, 4'h0, 3'h6, 4'hC);
      step(10'h2B5, 4'h0, 3'h0, 4'h8);
      end_of_test();
   end
endmodule : tb_usart_rx_status_flags
